// ==== rtl/uart_rx_pkg.sv ====
package uart_rx_pkg;

    // Register byte offsets
    localparam logic [3:0] OFS_CTRL_A    = 4'h0;
    localparam logic [3:0] OFS_CTRL_B    = 4'h4;
    localparam logic [3:0] OFS_CTRL_C    = 4'h8;
    localparam logic [3:0] OFS_DATA      = 4'hC;

    // ctrl_status_a bit positions
    localparam int A_RXC                 = 7;
    localparam int A_FE                  = 4;
    localparam int A_DOR                 = 3;
    localparam int A_UPE                 = 2;

    // ctrl_status_b bit positions
    localparam int B_RXCIE               = 7;
    localparam int B_RXEN                = 4;
    localparam int B_SIZE2               = 2;
    localparam int B_RX_NINTH            = 1;
    localparam int B_TX_NINTH            = 0;

    // ctrl_status_c bit positions
    localparam int C_PCHK                = 5;
    localparam int C_PODD                = 4;
    localparam int C_STOP                = 3;
    localparam int C_SIZE1               = 2;
    localparam int C_SIZE0               = 1;

    // Reset values
    localparam logic [7:0] CTRL_B_RESET  = 8'h00;
    localparam logic [7:0] CTRL_C_RESET  = 8'h06;

    // Character size codes
    localparam logic [2:0] SIZE_FIVE     = 3'h0;
    localparam logic [2:0] SIZE_SIX      = 3'h1;
    localparam logic [2:0] SIZE_SEVEN    = 3'h2;
    localparam logic [2:0] SIZE_NINE     = 3'h7;

    // Bit counts
    localparam logic [3:0] BITS_FIVE     = 4'h5;
    localparam logic [3:0] BITS_SIX      = 4'h6;
    localparam logic [3:0] BITS_SEVEN    = 4'h7;
    localparam logic [3:0] BITS_EIGHT    = 4'h8;
    localparam logic [3:0] BITS_NINE     = 4'h9;

    // AXI responses
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    typedef struct packed {
        logic [2:0] size;
        logic       parity_on;
        logic       parity_odd;
    } format_type;

    typedef struct packed {
        logic [7:0] data;
        logic       ninth;
        logic       frame_err;
        logic       parity_err;
    } frame_type;

    typedef struct packed {
        frame_type  frame;
        logic       overrun;
    } entry_type;

    typedef enum logic [1:0] {
        SH_IDLE,
        SH_DATA,
        SH_PARITY,
        SH_STOP
    } shift_state_type;

    function automatic logic [3:0] data_bits(input logic [2:0] size);
        case (size)
            SIZE_FIVE:  data_bits = BITS_FIVE;
            SIZE_SIX:   data_bits = BITS_SIX;
            SIZE_SEVEN: data_bits = BITS_SEVEN;
            SIZE_NINE:  data_bits = BITS_NINE;
            default:    data_bits = BITS_EIGHT;
        endcase
    endfunction

endpackage

// ==== rtl/uart_rx_shifter.sv ====
`timescale 1ns/1ps
`default_nettype none

module uart_rx_shifter
    import uart_rx_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Control
    input  wire logic       enable,
    input  wire format_type fmt,
    // Sampled line, one decided bit per tick
    input  wire logic       line,
    input  wire logic       bit_tick,
    // Results
    output logic            start_seen,
    output logic            frame_valid,
    output frame_type       frame
);

    typedef struct packed {
        shift_state_type st;
        logic [3:0]      cnt;
        logic [8:0]      bits;
        logic            pbit;
        logic            start;
        logic            valid;
        frame_type       frame;
    } shifter_state_type;

    shifter_state_type state;
    shifter_state_type next_state;

    always_comb begin
        logic [3:0] nbits;
        nbits = data_bits(fmt.size);
        next_state = state;
        next_state.start = 1'b0;
        next_state.valid = 1'b0;
        if (!enable) begin
            next_state.st = SH_IDLE;
            next_state.cnt = 4'h0;
        end else if (bit_tick) begin
            case (state.st)
                SH_IDLE: begin
                    if (!line) begin
                        next_state.st = SH_DATA;
                        next_state.cnt = 4'h0;
                        next_state.bits = 9'h000;
                        next_state.start = 1'b1;
                    end
                end
                SH_DATA: begin
                    next_state.bits[state.cnt] = line;
                    if (state.cnt == nbits - 4'h1) begin
                        next_state.st = fmt.parity_on ? SH_PARITY : SH_STOP;
                    end else begin
                        next_state.cnt = state.cnt + 4'h1;
                    end
                end
                SH_PARITY: begin
                    next_state.pbit = line;
                    next_state.st = SH_STOP;
                end
                SH_STOP: begin
                    // Further stop bits look like idle line
                    next_state.st = SH_IDLE;
                    next_state.valid = 1'b1;
                    next_state.frame.data = state.bits[7:0];
                    next_state.frame.ninth = (nbits == BITS_NINE) & state.bits[8];
                    next_state.frame.frame_err = ~line;
                    next_state.frame.parity_err = fmt.parity_on
                        & ((^state.bits ^ state.pbit) != fmt.parity_odd);
                end
                default: next_state.st = SH_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign start_seen  = state.start;
    assign frame_valid = state.valid;
    assign frame       = state.frame;

endmodule

`default_nettype wire

// ==== rtl/uart_rx_buffer.sv ====
// Contract
// - Ninth bit readable in control register B
// - Data read advances the receive buffer
// - Receive-complete set while buffer holds frames
// - Receiver off empties buffer, clears flag
// - Interrupt requested while flag and enables set
// - Error flags buffered with frame, read A
// - Writes to error flags have no effect
// - Error flags never raise interrupts
// - Frame error mirrors first stop bit
// - Only first stop bit is checked
// - Overrun: buffer full, frame waiting, start
// - Overrun clears on successful transfer
// - Parity error zero when checking off
// - Upper bit enables, lower selects parity
// - Parity computed, compared, stored with data
// - Parity error only if enabled at arrival
// - Receiver disable is immediate, aborts frame
// - Disabled receiver releases the pin
// - Start bit begins frame, stop completes
// - Unused upper data bits read zero
// - Enable gives pin to receiver
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module uart_rx_buffer
    import uart_rx_pkg::*;
#(
    parameter int AXI_ADDR_W = 8
)
(
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write address
    input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Serial side
    input  wire logic                  serial_rx_pin,
    input  wire logic                  rx_bit_tick,
    output logic                       rx_pin_claimed,
    // Interrupt
    input  wire logic                  global_irq_on,
    output logic                       rx_complete_irq
);

    initial begin
        if (AXI_ADDR_W < 4) begin
            $error("AXI_ADDR_W must be at least 4");
        end
    end

    typedef struct packed {
        logic [1:0]            sync;
        logic                  rx_complete_irq_on;
        logic                  receiver_on_bit;
        logic                  buffered_ninth_bit;
        logic [2:0]            char_size_field;
        logic                  parity_check_on;
        logic                  parity_odd_select;
        logic                  stop_bit_count_select;
        entry_type [1:0]       fifo;
        logic                  rd_ptr;
        logic [1:0]            count;
        logic                  pend_valid;
        frame_type             pend;
        logic                  lost;
        logic                  aw_got;
        logic [AXI_ADDR_W-1:0] aw_addr;
        logic                  w_got;
        logic [7:0]            w_data;
        logic                  w_lane0;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [1:0]            rresp;
        logic [31:0]           rdata;
    } buffer_state_type;

    buffer_state_type state;
    buffer_state_type next_state;

    format_type fmt;
    logic       start_seen;
    logic       frame_valid;
    frame_type  frame;

    function automatic logic hits(input logic [AXI_ADDR_W-1:0] addr,
                                  input logic [3:0] ofs);
        hits = (addr == AXI_ADDR_W'(ofs));
    endfunction

    function automatic logic mapped(input logic [AXI_ADDR_W-1:0] addr);
        mapped = hits(addr, OFS_CTRL_A) | hits(addr, OFS_CTRL_B)
               | hits(addr, OFS_CTRL_C) | hits(addr, OFS_DATA);
    endfunction

    assign fmt.size       = state.char_size_field;
    assign fmt.parity_on  = state.parity_check_on;
    assign fmt.parity_odd = state.parity_odd_select;

    uart_rx_shifter shifter (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .enable      (state.receiver_on_bit),
        .fmt         (fmt),
        .line        (state.sync[1] | ~state.receiver_on_bit),
        .bit_tick    (rx_bit_tick),
        .start_seen  (start_seen),
        .frame_valid (frame_valid),
        .frame       (frame)
    );

    always_comb begin
        entry_type             head;
        logic                  have_aw;
        logic                  have_w;
        logic [AXI_ADDR_W-1:0] waddr;
        logic [7:0]            wdata;
        logic                  wlane;
        logic [7:0]            rbyte;
        logic [7:0]            mask;
        logic [1:0]            cnt;
        logic                  wr_idx;

        next_state = state;
        mask = 8'h00;
        wr_idx = 1'b0;
        head = state.fifo[state.rd_ptr];
        rbyte = 8'h00;
        cnt = state.count;

        next_state.sync = {state.sync[0], serial_rx_pin};

        // Writes: address and data in either order
        have_aw = state.aw_got | (s_axi_awvalid & s_axi_awready);
        have_w = state.w_got | (s_axi_wvalid & s_axi_wready);
        waddr = state.aw_got ? state.aw_addr : s_axi_awaddr;
        wdata = state.w_got ? state.w_data : s_axi_wdata[7:0];
        wlane = state.w_got ? state.w_lane0 : s_axi_wstrb[0];
        if (s_axi_awvalid & s_axi_awready) begin
            next_state.aw_got = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
            next_state.w_got = 1'b1;
            next_state.w_data = s_axi_wdata[7:0];
            next_state.w_lane0 = s_axi_wstrb[0];
        end
        if (have_aw & have_w) begin
            next_state.aw_got = 1'b0;
            next_state.w_got = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = mapped(waddr) ? RESP_OKAY : RESP_SLVERR;
            // Register A has no writable bits: error flags ignore writes
            if (wlane & hits(waddr, OFS_CTRL_B)) begin
                next_state.rx_complete_irq_on = wdata[B_RXCIE];
                next_state.receiver_on_bit = wdata[B_RXEN];
                next_state.char_size_field[2] = wdata[B_SIZE2];
                next_state.buffered_ninth_bit = wdata[B_TX_NINTH];
            end
            if (wlane & hits(waddr, OFS_CTRL_C)) begin
                next_state.parity_check_on = wdata[C_PCHK];
                next_state.parity_odd_select = wdata[C_PODD];
                next_state.stop_bit_count_select = wdata[C_STOP];
                next_state.char_size_field[1:0] = {wdata[C_SIZE1], wdata[C_SIZE0]};
            end
        end
        if (state.bvalid & s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end

        // Reads: status is taken from the head entry before any pop
        if (state.rvalid & s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end
        if (s_axi_arvalid & s_axi_arready) begin
            if (hits(s_axi_araddr, OFS_CTRL_A)) begin
                rbyte[A_RXC] = (cnt != 2'h0);
                rbyte[A_FE] = (cnt != 2'h0) & head.frame.frame_err;
                rbyte[A_DOR] = (cnt != 2'h0) & head.overrun;
                rbyte[A_UPE] = (cnt != 2'h0) & head.frame.parity_err;
            end else if (hits(s_axi_araddr, OFS_CTRL_B)) begin
                rbyte[B_RXCIE] = state.rx_complete_irq_on;
                rbyte[B_RXEN] = state.receiver_on_bit;
                rbyte[B_SIZE2] = state.char_size_field[2];
                rbyte[B_RX_NINTH] = (cnt != 2'h0) & head.frame.ninth;
                rbyte[B_TX_NINTH] = state.buffered_ninth_bit;
            end else if (hits(s_axi_araddr, OFS_CTRL_C)) begin
                rbyte[C_PCHK] = state.parity_check_on;
                rbyte[C_PODD] = state.parity_odd_select;
                rbyte[C_STOP] = state.stop_bit_count_select;
                rbyte[C_SIZE1] = state.char_size_field[1];
                rbyte[C_SIZE0] = state.char_size_field[0];
            end else if (hits(s_axi_araddr, OFS_DATA)) begin
                mask = 8'hFF >> (4'h8 - data_bits(state.char_size_field));
                if (data_bits(state.char_size_field) > BITS_EIGHT) begin
                    mask = 8'hFF;
                end
                rbyte = (cnt != 2'h0) ? (head.frame.data & mask) : 8'h00;
                if (cnt != 2'h0) begin
                    next_state.rd_ptr = ~state.rd_ptr;
                    cnt = cnt - 2'h1;
                end
            end
            next_state.rvalid = 1'b1;
            next_state.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            next_state.rdata = {24'h00_0000, rbyte};
        end

        // Overrun: queue full, a frame waiting, and a new start arrives
        if (start_seen & state.pend_valid & (cnt == 2'h2)) begin
            next_state.lost = 1'b1;
        end
        if (frame_valid) begin
            // A waiting frame left in place is the one lost
            next_state.pend_valid = 1'b1;
            next_state.pend = frame;
        end else if (state.pend_valid & (cnt != 2'h2)) begin
            wr_idx = next_state.rd_ptr ^ cnt[0];
            next_state.fifo[wr_idx].frame = state.pend;
            next_state.fifo[wr_idx].overrun = state.lost | next_state.lost;
            next_state.lost = 1'b0;
            next_state.pend_valid = 1'b0;
            cnt = cnt + 2'h1;
        end
        next_state.count = cnt;

        // Receiver off drops everything at once
        if (!state.receiver_on_bit) begin
            next_state.count = 2'h0;
            next_state.rd_ptr = 1'b0;
            next_state.pend_valid = 1'b0;
            next_state.lost = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
            state.rx_complete_irq_on <= CTRL_B_RESET[B_RXCIE];
            state.receiver_on_bit <= CTRL_B_RESET[B_RXEN];
            state.buffered_ninth_bit <= CTRL_B_RESET[B_TX_NINTH];
            state.char_size_field <= {CTRL_B_RESET[B_SIZE2], CTRL_C_RESET[C_SIZE1],
                                      CTRL_C_RESET[C_SIZE0]};
            state.parity_check_on <= CTRL_C_RESET[C_PCHK];
            state.parity_odd_select <= CTRL_C_RESET[C_PODD];
            state.stop_bit_count_select <= CTRL_C_RESET[C_STOP];
        end else begin
            state <= next_state;
        end
    end

    assign s_axi_awready = ~state.aw_got & ~state.bvalid;
    assign s_axi_wready  = ~state.w_got & ~state.bvalid;
    assign s_axi_bvalid  = state.bvalid;
    assign s_axi_bresp   = state.bresp;
    assign s_axi_arready = ~state.rvalid;
    assign s_axi_rvalid  = state.rvalid;
    assign s_axi_rresp   = state.rresp;
    assign s_axi_rdata   = state.rdata;

    assign rx_pin_claimed = state.receiver_on_bit;
    // Error flags take no part in the request
    assign rx_complete_irq = (state.count != 2'h0)
                           & state.rx_complete_irq_on & global_irq_on;

endmodule

`default_nettype wire

// ==== tb/uart_rx_buffer_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none

module uart_rx_buffer_asserts
    import uart_rx_pkg::*;
#(
    parameter int AXI_ADDR_W = 8
)
(
    // Clock and reset
    input wire logic                  aclk,
    input wire logic                  aresetn,
    // Register bus
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_awready,
    input wire logic [31:0]           s_axi_wdata,
    input wire logic [3:0]            s_axi_wstrb,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_wready,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_bready,
    input wire logic [31:0]           s_axi_rdata,
    input wire logic                  s_axi_rvalid,
    input wire logic                  s_axi_rready,
    // Receiver side
    input wire logic                  rx_pin_claimed,
    input wire logic                  global_irq_on,
    input wire logic                  rx_complete_irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Bench offers address and data together, so both go in one edge
    sequence b_write(bit on);
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0]
            && s_axi_awaddr == AXI_ADDR_W'(OFS_CTRL_B) && s_axi_wdata[B_RXEN] == on;
    endsequence

    chk_on_claims: assert property (b_write(1'b1) |-> ##[1:3] rx_pin_claimed)
        else $error("receiver enable did not claim the pin");
    chk_off_release: assert property (b_write(1'b0) |-> ##[1:3] !rx_pin_claimed)
        else $error("receiver disable did not release the pin");
    chk_off_flush: assert property (b_write(1'b0) |-> ##[1:3] !rx_complete_irq [*3])
        else $error("receiver disable left the receive request up");
    chk_irq_global: assert property (!global_irq_on |-> !rx_complete_irq)
        else $error("receive request without global enable");
    chk_irq_owner: assert property (rx_complete_irq |-> rx_pin_claimed)
        else $error("receive request while receiver is off");
    chk_b_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped before taken");
    chk_r_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata))
        else $error("read data changed before taken");
    chk_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address accepted with response pending");
endmodule

bind uart_rx_buffer uart_rx_buffer_asserts #(.AXI_ADDR_W(AXI_ADDR_W)) u_uart_rx_buffer_asserts (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rx_pin_claimed, .global_irq_on,
    .rx_complete_irq
);

`default_nettype wire

// ==== tb/uart_tx_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module uart_tx_model (
    // Clock
    input  wire logic aclk,
    // Serial line and bit strobe
    output logic      serial_rx_pin,
    output logic      rx_bit_tick
);
    initial begin
        serial_rx_pin = 1'b1;
        rx_bit_tick   = 1'b0;
    end

    // Line settles past the two sync flops before its tick
    task automatic put_bit(input logic b);
        @(posedge aclk);
        serial_rx_pin <= b;
        repeat (3) @(posedge aclk);
        rx_bit_tick <= 1'b1;
        @(posedge aclk);
        rx_bit_tick <= 1'b0;
    endtask

    // Only one stop bit is ever sent; idle gap covers the receive pipeline
    task automatic send(input logic [8:0] d, input int n, input logic pen, input logic pb,
                        input logic stp);
        put_bit(1'b0);
        for (int i = 0; i < n; i++) put_bit(d[i]);
        if (pen) put_bit(pb);
        put_bit(stp);
        @(posedge aclk);
        serial_rx_pin <= 1'b1;
        repeat (6) @(posedge aclk);
    endtask
endmodule

`default_nettype wire

// ==== tb/uart_rx_buffer_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module uart_rx_buffer_test
    import uart_rx_pkg::*;
;
    localparam logic [7:0] addr_a = {4'h0, OFS_CTRL_A};
    localparam logic [7:0] addr_b = {4'h0, OFS_CTRL_B};
    localparam logic [7:0] addr_c = {4'h0, OFS_CTRL_C};
    localparam logic [7:0] addr_d = {4'h0, OFS_DATA};

    logic        aclk = 1'b0, aresetn = 1'b0, global_irq_on = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        serial_rx_pin, rx_bit_tick, rx_pin_claimed, rx_complete_irq;
    int          err_count = 0, n_tests = 0;
    always #25 aclk = ~aclk;
    uart_rx_buffer #(.AXI_ADDR_W(8)) u_uart_rx_buffer (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_rx_pin, .rx_bit_tick,
        .rx_pin_claimed, .global_irq_on, .rx_complete_irq
    );

    uart_tx_model u_uart_tx_model (.aclk, .serial_rx_pin, .rx_bit_tick);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("mismatches=%0d comparisons=%0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Ready is sampled mid-cycle, where it equals its value at the next edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ha, hw, hb;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= {24'h00_0000, d};
        s_axi_wstrb   <= 4'hf;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (int i = 0; i < 100; i++) begin
            @(negedge aclk);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid && s_axi_bready;
            r  = s_axi_bresp;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            if (hb) begin
                s_axi_bready <= 1'b0;
                check(32'(r), 32'(er));
                return;
            end
        end
        err_count++;
        close_out();
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        logic        ha, hr;
        logic [31:0] d;
        logic [1:0]  r;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (int i = 0; i < 100; i++) begin
            @(negedge aclk);
            ha = s_axi_arvalid && s_axi_arready;
            hr = s_axi_rvalid && s_axi_rready;
            d  = s_axi_rdata;
            r  = s_axi_rresp;
            @(posedge aclk);
            if (ha) s_axi_arvalid <= 1'b0;
            if (hr) begin
                s_axi_rready <= 1'b0;
                check(d, {24'h00_0000, e});
                check(32'(r), 32'(er));
                return;
            end
        end
        err_count++;
        close_out();
    endtask

    initial begin
        repeat (50000) @(posedge aclk);
        err_count++;
        close_out();
    end

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(addr_b, CTRL_B_RESET, RESP_OKAY);
        rd(addr_c, CTRL_C_RESET, RESP_OKAY);
        rd(addr_a, 8'h00, RESP_OKAY);
        rd(8'h10, 8'h00, RESP_SLVERR);
        wr(8'h10, 8'hff, RESP_SLVERR);
        check(32'(rx_pin_claimed), 32'h0000_0000);
        wr(addr_b, 8'h90, RESP_OKAY);
        @(negedge aclk);
        check(32'(rx_pin_claimed), 32'h0000_0001);
        wr(addr_c, 8'h0e, RESP_OKAY);
        u_uart_tx_model.send(9'h0a5, 8, 1'b0, 1'b0, 1'b1);
        rd(addr_a, 8'h80, RESP_OKAY);
        check(32'(rx_complete_irq), 32'h0000_0000);
        global_irq_on <= 1'b1;
        @(negedge aclk);
        check(32'(rx_complete_irq), 32'h0000_0001);
        rd(addr_d, 8'ha5, RESP_OKAY);
        rd(addr_a, 8'h00, RESP_OKAY);
        check(32'(rx_complete_irq), 32'h0000_0000);
        u_uart_tx_model.send(9'h03c, 8, 1'b0, 1'b0, 1'b0);
        rd(addr_a, 8'h90, RESP_OKAY);
        wr(addr_a, 8'h1c, RESP_OKAY);
        rd(addr_a, 8'h90, RESP_OKAY);
        wr(addr_a, 8'h00, RESP_OKAY);
        rd(addr_d, 8'h3c, RESP_OKAY);
        for (int s = 0; s < 3; s++) begin
            wr(addr_c, 8'(s << 1), RESP_OKAY);
            u_uart_tx_model.send(9'h1ff, s + 5, 1'b0, 1'b0, 1'b1);
            rd(addr_d, 8'hff >> (3 - s), RESP_OKAY);
        end
        wr(addr_c, 8'h06, RESP_OKAY);
        wr(addr_b, 8'h94, RESP_OKAY);
        u_uart_tx_model.send(9'h13c, 9, 1'b0, 1'b0, 1'b1);
        rd(addr_b, 8'h96, RESP_OKAY);
        rd(addr_d, 8'h3c, RESP_OKAY);
        rd(addr_b, 8'h94, RESP_OKAY);
        wr(addr_b, 8'h90, RESP_OKAY);
        // Data 0x03 has even weight: the good parity bit equals the odd select
        for (int o = 0; o < 2; o++) begin
            wr(addr_c, 8'h26 | 8'(o << 4), RESP_OKAY);
            u_uart_tx_model.send(9'h003, 8, 1'b1, 1'(o), 1'b1);
            u_uart_tx_model.send(9'h003, 8, 1'b1, 1'(!o), 1'b1);
            wr(addr_c, 8'h06, RESP_OKAY);
            rd(addr_a, 8'h80, RESP_OKAY);
            rd(addr_d, 8'h03, RESP_OKAY);
            rd(addr_a, 8'h84, RESP_OKAY);
            rd(addr_d, 8'h03, RESP_OKAY);
        end
        for (int k = 1; k < 5; k++) u_uart_tx_model.send(9'(k * 17), 8, 1'b0, 1'b0, 1'b1);
        rd(addr_a, 8'h80, RESP_OKAY);
        rd(addr_d, 8'h11, RESP_OKAY);
        rd(addr_a, 8'h80, RESP_OKAY);
        rd(addr_d, 8'h22, RESP_OKAY);
        rd(addr_a, 8'h88, RESP_OKAY);
        rd(addr_d, 8'h44, RESP_OKAY);
        u_uart_tx_model.send(9'h055, 8, 1'b0, 1'b0, 1'b1);
        rd(addr_a, 8'h80, RESP_OKAY);
        rd(addr_d, 8'h55, RESP_OKAY);
        rd(addr_a, 8'h00, RESP_OKAY);
        u_uart_tx_model.send(9'h066, 8, 1'b0, 1'b0, 1'b1);
        wr(addr_b, 8'h00, RESP_OKAY);
        rd(addr_a, 8'h00, RESP_OKAY);
        check(32'(rx_pin_claimed), 32'h0000_0000);
        wr(addr_b, 8'h90, RESP_OKAY);
        // All-ones data keeps the rest of the line high after the abort
        fork
            u_uart_tx_model.send(9'h0ff, 8, 1'b0, 1'b0, 1'b1);
            begin
                repeat (20) @(posedge aclk);
                wr(addr_b, 8'h00, RESP_OKAY);
                wr(addr_b, 8'h90, RESP_OKAY);
            end
        join
        rd(addr_a, 8'h00, RESP_OKAY);
        u_uart_tx_model.send(9'h077, 8, 1'b0, 1'b0, 1'b1);
        rd(addr_d, 8'h77, RESP_OKAY);
        close_out();
    end
endmodule

`default_nettype wire
